// File: pkg/scp_defs.svh
// scp_defs.svh: offsets, field positions, reset values and timing counts
// for the system-clock control block.
// assumes a 32-bit register port with byte addresses, one aligned word per register.
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// register offsets (byte addresses, one aligned word each)
`define SCP_OFS_CTRL 8'h00
`define SCP_OFS_FB_INT 8'h04
`define SCP_OFS_FRAC_TOP 8'h08
`define SCP_OFS_FRAC_BOT 8'h0C
`define SCP_OFS_STATUS 8'h10
`define SCP_OFS_IRQ_STAT 8'h14
`define SCP_OFS_IRQ_CLR 8'h18
`define SCP_OFS_IRQ_EN 8'h1C

// control register fields
`define SCP_CTRL_MODE_LSB 0
`define SCP_CTRL_INDIV_LSB 2
`define SCP_CTRL_RATE_LSB 5

// loop operating select codes
`define SCP_MODE_BYPASS 2'h0
`define SCP_MODE_NORMAL 2'h1
`define SCP_MODE_RATE_MATCH 2'h2

// predivider codes
`define SCP_INDIV_DIV16 3'h4

// feedback divider widths: 7 integer, 5 + 8 fractional
`define SCP_FB_INT_W 7
`define SCP_FRAC_TOP_W 5
`define SCP_FRAC_BOT_W 8

// reset values
`define SCP_CTRL_RST 9'h000
`define SCP_FB_INT_RST 7'h00
`define SCP_FRAC_TOP_RST 5'h00
`define SCP_FRAC_BOT_RST 8'h00
`define SCP_IRQ_EN_RST 4'h0

// interrupt bit positions
`define SCP_IRQ_MCLK_CHG 0
`define SCP_IRQ_LOCK 1
`define SCP_IRQ_UNLOCK 2
`define SCP_IRQ_SWITCHED 3
`define SCP_IRQ_W 4

// clock rate and dead time between deselect and select of a source
`define SCP_CLK_MHZ 25
`define SCP_DEAD_NS 200
`define SCP_DEAD_CYC ((`SCP_DEAD_NS * `SCP_CLK_MHZ + 999) / 1000)

`endif

// File: pkg/scp_pkg.sv
// scp_pkg.sv: types shared by the system-clock control block.
// assumes scp_defs.svh for all numeric constants.
package scp_pkg;

  // source of the internal system clock
  typedef enum logic [1:0] {
    SCP_SRC_MCLK,
    SCP_SRC_PLL,
    SCP_SRC_OSC
  } scp_src_t;

  // source switch sequencer
  typedef enum logic [1:0] {
    SCP_ST_STABLE,
    SCP_ST_BREAK,
    SCP_ST_MAKE
  } scp_state_t;

  // software configuration carried as one bundle
  typedef struct packed {
    logic [3:0] rate_code;
    logic [2:0] indiv;
    logic [1:0] mode;
  } scp_cfg_t;

  // clock mux selects, one-hot, all low while switching
  typedef struct packed {
    logic osc;
    logic pll;
    logic mclk;
  } scp_sel_t;

  // feedback divider: integer then fractional high and low parts
  typedef struct packed {
    logic [6:0] int_part;
    logic [4:0] frac_top;
    logic [7:0] frac_bot;
  } scp_fb_t;

endpackage : scp_pkg

// File: logic/scp_clock_ctrl.sv
// scp_clock_ctrl.sv: digital control around the system-clock generator.
// assumes analog mclk detector and pll lock flags arrive asynchronously,
// the active mode flag comes from logic on sys_clk, and the clock mux
// obeys the one-hot selects it is given.
//
// Function
// - mode 00 bypasses pll, uses master clock
// - rate code chooses 12.288 or 11.2896 MHz
// - no master clock: oscillator, analog only
// - mode 01 enables pll, switch after lock
// - predivider codes give divide 1 to 16
// - vco equals reference times divider, eight times
// - divider: seven integer, thirteen fraction bits
// - device applies the programmed feedback divider
// - detector bit 0 marks mclk as input
// - mode 10 enables word-clock rate matching
// - oscillator runs active without mclk, stops standby
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "scp_defs.svh"

module scp_clock_ctrl (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic mclk_det_in, // analog detector, mclk above 1 MHz
  input wire logic pll_lock_in, // analog pll phase lock flag
  input wire logic active_mode, // codec active, low in standby
  output scp_pkg::scp_sel_t clk_sel, // one-hot system clock mux select
  output logic pll_en, // pll power enable
  output logic srm_en, // rate-matching enable
  output logic pll_rst, // one-cycle pll restart pulse
  output logic refosc_en, // reference oscillator enable
  output logic digital_ok, // digital audio paths usable
  output logic [2:0] indiv_code, // predivider code to the pll
  output logic [4:0] indiv_ratio, // predivider ratio n
  output scp_pkg::scp_fb_t fb_div, // feedback divider to the pll
  output logic need_12m288, // target clock is 12.288 MHz
  output logic irq // level interrupt
);
  import scp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // functions

  // sample rate family: high for the 48 kHz family
  function automatic logic fam_48k(input logic [3:0] code);
    logic r;
    r = 1'b0;
    unique case (code)
      4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hF: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : fam_48k

  // code is one of the documented sample rates
  function automatic logic rate_valid(input logic [3:0] code);
    logic r;
    r = 1'b0;
    unique case (code)
      4'h2, 4'h6, 4'hA, 4'hE: r = 1'b1;
      default: r = fam_48k(code);
    endcase
    return r;
  endfunction : rate_valid

  // predivider ratio; codes above divide-by-16 clamp to it
  function automatic logic [4:0] div_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `SCP_INDIV_DIV16) ? `SCP_INDIV_DIV16 : code;
    return 5'h01 << c;
  endfunction : div_of

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // two stages for each asynchronous flag; first stage read only here
  logic mdet_s1_r, mdet_s2_r; // mclk detect chain
  logic lock_s1_r, lock_s2_r; // pll lock chain

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mdet_s1_r <= 1'b0;
      mdet_s2_r <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      mdet_s1_r <= mclk_det_in;
      mdet_s2_r <= mdet_s1_r;
      lock_s1_r <= pll_lock_in;
      lock_s2_r <= lock_s1_r;
    end
  end

  // previous synchronised values for edge events
  logic mdet_d_r; // delayed mclk detect
  logic lock_d_r; // delayed lock

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mdet_d_r <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      mdet_d_r <= mdet_s2_r;
      lock_d_r <= lock_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file

  scp_cfg_t cfg_r; // mode, predivider, rate code
  scp_fb_t fb_r; // feedback divider
  logic [`SCP_IRQ_W-1:0] irq_stat_r; // sticky events
  logic [`SCP_IRQ_W-1:0] irq_en_r; // interrupt enables
  logic [31:0] rdata_r; // read data register
  logic pll_rst_r; // pll restart pulse
  logic refosc_en_r; // oscillator enable, also shown in status

  // address decode
  wire wr_ctrl = reg_wr && (reg_addr == `SCP_OFS_CTRL);
  wire wr_int = reg_wr && (reg_addr == `SCP_OFS_FB_INT);
  wire wr_ftop = reg_wr && (reg_addr == `SCP_OFS_FRAC_TOP);
  wire wr_fbot = reg_wr && (reg_addr == `SCP_OFS_FRAC_BOT);
  wire wr_clr = reg_wr && (reg_addr == `SCP_OFS_IRQ_CLR);
  wire wr_en = reg_wr && (reg_addr == `SCP_OFS_IRQ_EN);

  // configuration writes; the divider fields are stored as written
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= `SCP_CTRL_RST;
      fb_r.int_part <= `SCP_FB_INT_RST;
      fb_r.frac_top <= `SCP_FRAC_TOP_RST;
      fb_r.frac_bot <= `SCP_FRAC_BOT_RST;
      irq_en_r <= `SCP_IRQ_EN_RST;
    end else begin
      if (wr_ctrl) cfg_r <= reg_wdata[8:0];
      if (wr_int) fb_r.int_part <= reg_wdata[`SCP_FB_INT_W-1:0];
      if (wr_ftop) fb_r.frac_top <= reg_wdata[`SCP_FRAC_TOP_W-1:0];
      if (wr_fbot) fb_r.frac_bot <= reg_wdata[`SCP_FRAC_BOT_W-1:0];
      if (wr_en) irq_en_r <= reg_wdata[`SCP_IRQ_W-1:0];
    end
  end

  // rewriting the integer part restarts the loop so it relocks cleanly
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) pll_rst_r <= 1'b0;
    else pll_rst_r <= wr_int;
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection

  // mode decode
  wire mode_bypass = (cfg_r.mode == `SCP_MODE_BYPASS);
  wire mode_normal = (cfg_r.mode == `SCP_MODE_NORMAL);
  wire mode_srm = (cfg_r.mode == `SCP_MODE_RATE_MATCH);
  // reserved code 11 behaves as bypass: safest, no loop running
  wire loop_on = mode_normal || mode_srm;
  wire mclk_ok = mdet_s2_r;

  // wanted source: oscillator if no mclk, pll only once locked
  scp_src_t want_src;
  assign want_src = !mclk_ok ? SCP_SRC_OSC :
                    (loop_on && lock_s2_r) ? SCP_SRC_PLL :
                    SCP_SRC_MCLK;

  // select vector for a source
  scp_sel_t want_sel;
  assign want_sel.mclk = (want_src == SCP_SRC_MCLK);
  assign want_sel.pll = (want_src == SCP_SRC_PLL);
  assign want_sel.osc = (want_src == SCP_SRC_OSC);

  ////////////////////////////////////////////////////////////////////////
  // break-before-make switch sequencer

  scp_state_t state_r, state_nxt; // sequencer state
  scp_src_t cur_src_r, cur_src_nxt; // source now driving sysclk
  scp_sel_t sel_r, sel_nxt; // mux select register
  logic [7:0] dead_r, dead_nxt; // dead-time counter
  logic switched; // source change completed

  // all selects drop for the dead time so the mux never sees two
  // clocks at once and no output phase is cut short
  always_comb begin
    state_nxt = state_r;
    cur_src_nxt = cur_src_r;
    sel_nxt = sel_r;
    dead_nxt = dead_r;
    switched = 1'b0;
    unique case (state_r)
      SCP_ST_STABLE: begin
        if (want_src != cur_src_r) begin
          sel_nxt = '0;
          dead_nxt = 8'(`SCP_DEAD_CYC);
          state_nxt = SCP_ST_BREAK;
        end
      end
      SCP_ST_BREAK: begin
        if (dead_r > 8'h01) begin
          dead_nxt = dead_r - 8'h01;
        end else begin
          cur_src_nxt = want_src; // latest wish at the end of the gap
          state_nxt = SCP_ST_MAKE;
        end
      end
      SCP_ST_MAKE: begin
        sel_nxt = want_sel;
        cur_src_nxt = want_src;
        switched = 1'b1;
        state_nxt = SCP_ST_STABLE;
      end
    endcase
  end

  // sequencer registers; reset starts on the oscillator selection path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SCP_ST_MAKE;
      cur_src_r <= SCP_SRC_OSC;
      sel_r <= '0;
      dead_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cur_src_r <= cur_src_nxt;
      sel_r <= sel_nxt;
      dead_r <= dead_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  // event vector; set wins over a clear in the same cycle
  wire [`SCP_IRQ_W-1:0] ev = {switched,
                              lock_d_r && !lock_s2_r,
                              !lock_d_r && lock_s2_r,
                              mdet_d_r != mdet_s2_r};
  wire [`SCP_IRQ_W-1:0] clr = wr_clr ? reg_wdata[`SCP_IRQ_W-1:0] : '0;
  logic irq_r; // interrupt output register

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      irq_r <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  wire [31:0] status_w = {24'h0,
                          rate_valid(cfg_r.rate_code),
                          fam_48k(cfg_r.rate_code),
                          state_r != SCP_ST_STABLE,
                          cur_src_r,
                          refosc_en_r,
                          lock_s2_r,
                          mclk_ok};

  // read mux; unmapped and write-only addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      `SCP_OFS_CTRL: rd_mux = {23'h0, cfg_r};
      `SCP_OFS_FB_INT: rd_mux = {25'h0, fb_r.int_part};
      `SCP_OFS_FRAC_TOP: rd_mux = {27'h0, fb_r.frac_top};
      `SCP_OFS_FRAC_BOT: rd_mux = {24'h0, fb_r.frac_bot};
      `SCP_OFS_STATUS: rd_mux = status_w;
      `SCP_OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
      `SCP_OFS_IRQ_EN: rd_mux = {28'h0, irq_en_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rdata_r <= 32'h0000_0000;
    else rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // analog-facing controls

  logic pll_en_r; // pll enable
  logic srm_en_r; // rate matching enable
  logic digok_r; // digital paths usable
  logic [2:0] indiv_r; // predivider code
  logic [4:0] ratio_r; // predivider ratio
  scp_fb_t fbo_r; // applied feedback divider
  logic need12_r; // target frequency family

  // the loop multiplies the reference by fb_div and the vco sits at
  // eight times the target; software computes fb_div, hardware applies it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pll_en_r <= 1'b0;
      srm_en_r <= 1'b0;
      refosc_en_r <= 1'b0;
      digok_r <= 1'b0;
      indiv_r <= 3'h0;
      ratio_r <= 5'h01;
      fbo_r <= '0;
      need12_r <= 1'b0;
    end else begin
      pll_en_r <= loop_on && !mode_bypass;
      srm_en_r <= mode_srm;
      refosc_en_r <= active_mode && !mclk_ok;
      digok_r <= (cur_src_r != SCP_SRC_OSC) && (state_r == SCP_ST_STABLE);
      indiv_r <= cfg_r.indiv;
      ratio_r <= div_of(cfg_r.indiv);
      fbo_r <= fb_r;
      need12_r <= fam_48k(cfg_r.rate_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign reg_rdata = rdata_r;
  assign clk_sel = sel_r;
  assign pll_en = pll_en_r;
  assign srm_en = srm_en_r;
  assign pll_rst = pll_rst_r;
  assign refosc_en = refosc_en_r;
  assign digital_ok = digok_r;
  assign indiv_code = indiv_r;
  assign indiv_ratio = ratio_r;
  assign fb_div = fbo_r;
  assign need_12m288 = need12_r;
  assign irq = irq_r;

endmodule : scp_clock_ctrl

// File: tb/scp_clock_ctrl_chk.sv
// scp_clock_ctrl_chk.sv: port assertions for the system-clock control.
// assumes it is bound to scp_clock_ctrl and sees only its ports.
`timescale 1ns/10ps
`include "scp_defs.svh"
module scp_clock_ctrl_chk (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic mclk_det_in, // mclk detector flag
  input wire logic active_mode, // codec active level
  input wire scp_pkg::scp_sel_t clk_sel, // clock mux select
  input wire logic pll_en, // pll enable
  input wire logic srm_en, // rate-matching enable
  input wire logic pll_rst, // pll restart pulse
  input wire logic refosc_en, // oscillator enable
  input wire logic digital_ok, // digital paths usable
  input wire logic [2:0] indiv_code, // predivider code
  input wire logic [4:0] indiv_ratio // predivider ratio
);
  import scp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] low_cnt_r; // cycles with mclk absent, saturating
  ////////////////////////////////////////////////////////////////
  // absence counter: switching may take two gaps, so allow slack
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) low_cnt_r <= 6'h00;
    else if (mclk_det_in) low_cnt_r <= 6'h00;
    else if (low_cnt_r != 6'h3f) low_cnt_r <= low_cnt_r + 6'h01;
  end
  ////////////////////////////////////////////////////////////////
  AST_ONE_SRC: assert property ($onehot0(clk_sel))
    else $error("clock select not one-hot");
  AST_BREAK_FIRST: assert property ((clk_sel != $past(clk_sel)) && (clk_sel != 3'h0)
    |-> ($past(clk_sel) == 3'h0)) else $error("select changed without a gap");
  AST_DEAD_GAP: assert property (($past(clk_sel) != 3'h0) && (clk_sel == 3'h0)
    |-> (clk_sel == 3'h0) [*6] ##1 (clk_sel != 3'h0)) else $error("dead gap length wrong");
  AST_SRM_PLL: assert property (srm_en |-> pll_en)
    else $error("rate matching without pll");
  AST_OSC_ANALOG: assert property (clk_sel.osc && $past(clk_sel.osc) |-> !digital_ok)
    else $error("digital paths usable on oscillator");
  AST_RATIO: assert property (indiv_ratio ==
    ((indiv_code > 3'h4) ? 5'h10 : (5'h01 << indiv_code))) else $error("predivider ratio wrong");
  AST_RESTART: assert property (pll_rst == $past(reg_wr && (reg_addr == `SCP_OFS_FB_INT)))
    else $error("pll restart pulse wrong");
  AST_REFOSC_ACT: assert property (refosc_en |-> $past(active_mode))
    else $error("oscillator on in standby");
  AST_REFOSC_MCLK: assert property (mclk_det_in [*5] |-> !refosc_en)
    else $error("oscillator on with mclk");
  AST_OSC_NOMCLK: assert property ((low_cnt_r >= 6'h18) |-> clk_sel.osc)
    else $error("oscillator not selected without mclk");
endmodule : scp_clock_ctrl_chk

bind scp_clock_ctrl scp_clock_ctrl_chk i_scp_clock_ctrl_chk (.sys_clk(sys_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .mclk_det_in(mclk_det_in),
  .active_mode(active_mode), .clk_sel(clk_sel), .pll_en(pll_en), .srm_en(srm_en),
  .pll_rst(pll_rst), .refosc_en(refosc_en), .digital_ok(digital_ok),
  .indiv_code(indiv_code), .indiv_ratio(indiv_ratio));

// File: tb/scp_mclk_model.sv
// scp_mclk_model.sv: external master clock source and analog pll lock.
// assumes the bench sets source presence and lock delay per test.
`timescale 1ns/10ps
module scp_mclk_model (
  input wire logic sys_clk, // system clock
  input wire logic mclk_on, // source running at an audio rate
  input wire logic [7:0] lock_dly, // cycles from enable to lock
  input wire logic pll_en, // pll enable from the block
  output logic mclk_det_in, // detector flag
  output logic pll_lock_in // lock flag
);
  logic [7:0] cnt_r; // lock progress
  // audio-rate source, predivider matched by the bench
  assign mclk_det_in = mclk_on;
  // loop settles only while enabled with a reference present
  always_ff @(posedge sys_clk) begin
    if (!pll_en || !mclk_on) cnt_r <= 8'h00;
    else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
  end
  assign pll_lock_in = pll_en && mclk_on && (cnt_r >= lock_dly);
endmodule : scp_mclk_model

// File: tb/testbench.sv
// testbench.sv: self-checking bench for the system-clock control.
// assumes scp_clock_ctrl, scp_mclk_model and the bound checker.
`timescale 1ns/10ps
`include "scp_defs.svh"
module testbench;
  import scp_pkg::*;
  logic sys_clk = 1'b0; // 25 MHz clock
  logic resetn = 1'b0; // reset, active low
  logic [7:0] reg_addr = 8'h00; // register address
  logic [31:0] reg_wdata = 32'h0; // write data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic mclk_on = 1'b0; // source running
  logic [7:0] lock_dly = 8'h04; // lock delay
  logic active_mode = 1'b1; // codec active
  logic [31:0] reg_rdata, v, d; // read data and scratch
  logic mclk_det_in, pll_lock_in, pll_en, srm_en, pll_rst, refosc_en;
  logic digital_ok, need_12m288, irq; // status outputs
  scp_sel_t clk_sel; // mux select
  scp_fb_t fb_div; // feedback divider
  logic [2:0] indiv_code; // predivider code
  logic [4:0] indiv_ratio; // predivider ratio
  int num_errors = 0; // mismatches
  int checks_done = 0; // comparisons
  logic [31:0] seed = 32'hc414_cb4d; // xorshift state
  always #20 sys_clk = ~sys_clk;
  scp_clock_ctrl i_scp_clock_ctrl (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mclk_det_in(mclk_det_in), .pll_lock_in(pll_lock_in), .active_mode(active_mode),
    .clk_sel(clk_sel), .pll_en(pll_en), .srm_en(srm_en), .pll_rst(pll_rst),
    .refosc_en(refosc_en), .digital_ok(digital_ok), .indiv_code(indiv_code),
    .indiv_ratio(indiv_ratio), .fb_div(fb_div), .need_12m288(need_12m288), .irq(irq));
  scp_mclk_model i_scp_mclk_model (.sys_clk(sys_clk), .mclk_on(mclk_on),
    .lock_dly(lock_dly), .pll_en(pll_en), .mclk_det_in(mclk_det_in),
    .pll_lock_in(pll_lock_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // odd codes except 1101 belong to the 48 kHz family
  function automatic logic want_12m(input logic [3:0] c);
    return c[0] && (c != 4'hd);
  endfunction : want_12m
  // every listed rate code: the 48 kHz family plus 2, 6, a and e
  function automatic logic rate_ok(input logic [3:0] c);
    return want_12m(c) || (c == 4'h2) || (c == 4'h6) || (c == 4'ha) || (c == 4'he);
  endfunction : rate_ok
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // idle cycle after each strobe so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    r = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic wait_sel(input logic [2:0] exp, input string what);
    int n;
    n = 0;
    while (clk_sel !== exp && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk(what, exp, clk_sel);
    @(posedge sys_clk);
  endtask : wait_sel
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // watchdog: tests need about 300 cycles
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(`SCP_OFS_IRQ_CLR, d);
    chk("irq_clr read", 32'h0, d);
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    wait_sel(3'b100, "sel osc");
    @(negedge sys_clk);
    chk("refosc", 1, refosc_en);
    chk("dig_ok osc", 0, digital_ok);
    $display("test reset done");
    // rate, predivider and mode codes, random mixed with all modes
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      seed = xs(seed);
      v = {23'h0, i[3:0], i[2:0], (i < 4) ? i[1:0] : seed[1:0]};
      wr(`SCP_OFS_CTRL, v);
      rd(`SCP_OFS_CTRL, d);
      chk("ctrl", v, d);
      chk("need12", want_12m(i[3:0]), need_12m288);
      chk("indiv", i[2:0], indiv_code);
      chk("pll_en", v[1:0] == 2'h1 || v[1:0] == 2'h2, pll_en);
      chk("srm_en", v[1:0] == 2'h2, srm_en);
      chk("ratio", (i[2:0] > 3'h4) ? 32'h10 : (32'h1 << i[2:0]), indiv_ratio);
      rd(`SCP_OFS_STATUS, d);
      chk("status", {rate_ok(i[3:0]), want_12m(i[3:0]), 6'h14}, d[7:0]);
    end
    $display("test codes done");
    // example divider, a table row, then random dividers
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      seed = xs(seed);
      v = (i == 0) ? {12'h0, 7'h20, 13'h0} :
          (i == 1) ? {12'h0, 7'h1b, 5'h19, 8'h45} : {12'h0, seed[19:0]};
      wr(`SCP_OFS_FRAC_TOP, {27'h0, v[12:8]});
      wr(`SCP_OFS_FRAC_BOT, {24'h0, v[7:0]});
      wr(`SCP_OFS_FB_INT, {25'h0, v[19:13]});
      @(negedge sys_clk);
      chk("fb_div", v[19:0], fb_div);
    end
    $display("test divider done");
    // bypass on a present master clock, interrupt on switch
    @(posedge sys_clk);
    wr(`SCP_OFS_IRQ_EN, 32'h8);
    wr(`SCP_OFS_CTRL, 32'h0);
    wr(`SCP_OFS_IRQ_CLR, 32'hf);
    mclk_on <= 1'b1;
    wait_sel(3'b001, "sel mclk");
    rd(`SCP_OFS_STATUS, d);
    chk("det bit", 1, d[0]);
    chk("dig_ok mclk", 1, digital_ok);
    chk("irq on", 1, irq);
    wr(`SCP_OFS_IRQ_EN, 32'h0);
    @(negedge sys_clk);
    chk("irq masked", 0, irq);
    @(posedge sys_clk);
    wr(`SCP_OFS_IRQ_EN, 32'h8);
    @(negedge sys_clk);
    chk("irq sticky", 1, irq);
    @(posedge sys_clk);
    wr(`SCP_OFS_IRQ_CLR, 32'h8);
    @(negedge sys_clk);
    chk("irq cleared", 0, irq);
    $display("test bypass done");
    // normal mode: stays on mclk until lock, then pll
    @(posedge sys_clk);
    lock_dly <= 8'h28;
    wr(`SCP_OFS_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk("pre-lock sel", 3'b001, clk_sel);
    wait_sel(3'b010, "sel pll");
    repeat (2) @(posedge sys_clk);
    chk("dig_ok pll", 1, digital_ok);
    rd(`SCP_OFS_IRQ_STAT, d);
    chk("irq_stat", 32'hb, d);
    mclk_on <= 1'b0;
    wait_sel(3'b100, "mclk lost");
    rd(`SCP_OFS_STATUS, d);
    chk("det bit low", 0, d[0]);
    active_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("refosc standby", 0, refosc_en);
    $display("test pll done");
    results();
  end
endmodule : testbench
